// *** logic/pmr_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module pmr_sequencer
    import pmr_pkg::*;
#(
    parameter int SETTLE_CYCLES = FREQ_SETTLE_CYCLES,
    parameter logic [1:0] WDT_SRC = WDT_SRC_RC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic ext_reset_n_i,
    input wire logic [7:0] port_a_i,
    input wire logic halt_exec_i,
    input wire logic wdt_timeout_i,
    input wire logic [5:0] irq_flag_i,
    input wire logic [5:0] irq_enable_i,
    input wire logic stack_full_i,
    output pmr_ctrl_s ctrl_o
);
    // Interrupt sources fed by the slow crystal: timer0, timer1, rtc, dialer
    localparam logic [5:0] IRQ_SLOW_SRC = 6'h3a;

    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << 25)) begin
            $error("SETTLE_CYCLES out of range");
        end
    end

    pmr_state_s st_reg;
    pmr_state_s st_next;

    logic [7:0] idx;
    logic acc_hit;
    logic halted;
    logic awake;
    logic pin_reset;
    logic [7:0] pa_wake;
    logic [5:0] irq_wake;
    logic wdt_live_halt;
    logic [7:0] be_wdata;

    assign idx = avs_address_i[ADDR_W-1:2];
    assign acc_hit = (avs_read_i || avs_write_i) && !st_reg.resp_valid;
    assign halted = (st_reg.mode == MD_SLEEP) || (st_reg.mode == MD_IDLE);
    assign awake = (st_reg.mode == MD_NORMAL) || (st_reg.mode == MD_GREEN);
    assign pin_reset = !st_reg.rst_pin_sync[1];
    assign be_wdata = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;

    // Wake sources, pending-at-halt interrupts and Idle-dead sources masked
    always_comb begin
        pa_wake = (st_reg.pa_sync1 ^ st_reg.pa_last) & st_reg.wake_mask;
        irq_wake = irq_flag_i & st_reg.irq_armed;
        if (st_reg.mode == MD_IDLE) begin
            irq_wake = irq_wake & ~IRQ_SLOW_SRC;
        end
    end

    // Watchdog keeps counting in halt only on a live source
    always_comb begin
        unique case (WDT_SRC)
            WDT_SRC_INSTR: wdt_live_halt = 1'b0;
            WDT_SRC_32K: wdt_live_halt = (st_reg.mode != MD_IDLE);
            default: wdt_live_halt = 1'b1;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        st_next = st_reg;
        st_next.ctrl.wdt_clear = 1'b0;
        st_next.ctrl.warm_reset = 1'b0;
        st_next.ctrl.full_reset = 1'b0;
        st_next.ctrl.resume_irq = 1'b0;
        st_next.ctrl.resume_next = 1'b0;
        st_next.rst_pin_sync = {st_reg.rst_pin_sync[0], ext_reset_n_i};
        st_next.pa_sync0 = port_a_i;
        st_next.pa_sync1 = st_reg.pa_sync0;
        if (awake) begin
            st_next.pa_last = st_reg.pa_sync1;
        end
        // Frequency-up settle timer
        if (!st_reg.clock_mode[BIT_FREQ_UP]) begin
            st_next.settle_cnt = '0;
            st_next.settle_done = 1'b0;
        end else if (!st_reg.settle_done) begin
            if (st_reg.settle_cnt == 25'(SETTLE_CYCLES - 1)) begin
                st_next.settle_done = 1'b1;
            end else begin
                st_next.settle_cnt = st_reg.settle_cnt + 25'h1;
            end
        end
        // Bus access, answered one cycle after it is taken
        st_next.resp_valid = acc_hit;
        if (acc_hit && avs_read_i) begin
            unique case (idx)
                IDX_WDT_PRESCALE: st_next.rdata = {24'h0, st_reg.wdt_prescale};
                IDX_PROC_STATUS: st_next.rdata = {26'h0, st_reg.wdt_timeout,
                    st_reg.pwr_down, st_reg.status_low};
                IDX_CLOCK_MODE: st_next.rdata = {24'h0, st_reg.clock_mode};
                IDX_SEQ_STATUS: st_next.rdata = {27'h0, st_reg.settle_done,
                    st_reg.wake_by_irq, st_reg.mode};
                IDX_WAKE_MASK: st_next.rdata = {24'h0, st_reg.wake_mask};
                default: st_next.rdata = 32'h0;
            endcase
        end
        if (acc_hit && avs_write_i && avs_byteenable_i[0]) begin
            unique case (idx)
                IDX_WDT_PRESCALE: st_next.wdt_prescale = be_wdata;
                IDX_PROC_STATUS: st_next.status_low = be_wdata[3:0];
                IDX_CLOCK_MODE: st_next.clock_mode = {be_wdata[7:5], 5'h00};
                IDX_WAKE_MASK: st_next.wake_mask = be_wdata;
                default: ;
            endcase
        end
        // Mode sequencing
        unique case (st_reg.mode)
            MD_NORMAL, MD_GREEN: begin
                if (halt_exec_i && !st_reg.clock_mode[BIT_FAST_SEL]
                        && !st_reg.clock_mode[BIT_FREQ_UP]) begin
                    st_next.mode = st_reg.clock_mode[BIT_OSC_STOP] ? MD_IDLE
                        : MD_SLEEP;
                    st_next.irq_armed = ~irq_flag_i;
                    st_next.pwr_down = 1'b1;
                    st_next.wdt_timeout = 1'b0;
                    st_next.ctrl.wdt_clear = 1'b1;
                end else if (st_reg.clock_mode[BIT_FAST_SEL]
                        && st_reg.clock_mode[BIT_FREQ_UP] && st_reg.settle_done) begin
                    st_next.mode = MD_NORMAL;
                end else begin
                    st_next.mode = MD_GREEN;
                end
            end
            MD_SLEEP, MD_IDLE: begin
                if (|irq_wake || |pa_wake) begin
                    st_next.mode = MD_STARTUP;
                    st_next.startup_cnt = '0;
                    st_next.wake_by_irq = |(irq_wake & irq_enable_i) && !stack_full_i;
                end
            end
            MD_STARTUP: begin
                if (st_reg.startup_cnt == STARTUP_W'(STARTUP_CYCLES - 1)) begin
                    st_next.mode = MD_GREEN;
                    st_next.ctrl.resume_irq = st_reg.wake_by_irq;
                    st_next.ctrl.resume_next = !st_reg.wake_by_irq;
                end else begin
                    st_next.startup_cnt = st_reg.startup_cnt + STARTUP_W'(1);
                end
            end
        endcase
        // Resets take priority over everything above
        if (pin_reset || (wdt_timeout_i && (awake || (halted && wdt_live_halt)))) begin
            st_next.mode = MD_STARTUP;
            st_next.startup_cnt = '0;
            st_next.wake_by_irq = 1'b0;
            st_next.clock_mode[BIT_FAST_SEL] = 1'b0;
            st_next.clock_mode[BIT_OSC_STOP] = 1'b0;
            if (halted) begin
                st_next.clock_mode[BIT_FREQ_UP] = 1'b0;
            end
            if (pin_reset) begin
                st_next.ctrl.full_reset = 1'b1;
                st_next.wdt_prescale = RST_WDT_PRESCALE;
                st_next.wake_mask = RST_WAKE_MASK;
                if (halted) begin
                    st_next.wdt_timeout = 1'b0;
                    st_next.pwr_down = 1'b1;
                end
            end else if (awake) begin
                st_next.ctrl.full_reset = 1'b1;
                st_next.wdt_prescale = RST_WDT_PRESCALE;
                st_next.wdt_timeout = 1'b1;
            end else begin
                st_next.ctrl.warm_reset = 1'b1;
                st_next.wdt_timeout = 1'b1;
                st_next.pwr_down = 1'b1;
            end
        end
        // Clock and oscillator controls from the next mode, registered along with it
        st_next.ctrl.core_run = (st_next.mode == MD_NORMAL) || (st_next.mode == MD_GREEN);
        st_next.ctrl.fast_clk_sel = (st_next.mode == MD_NORMAL);
        st_next.ctrl.osc_32k_en = (st_next.mode != MD_IDLE);
        st_next.ctrl.osc_fast_en = st_next.clock_mode[BIT_FREQ_UP]
            && (st_next.mode != MD_IDLE) && (st_next.mode != MD_SLEEP);
        // Judged on the next mode so entering Idle stops a slow-clocked watchdog at once
        st_next.ctrl.wdt_run = st_next.ctrl.core_run || (WDT_SRC == WDT_SRC_RC)
            || (WDT_SRC == WDT_SRC_32K && st_next.mode != MD_IDLE);
    end

    // State register; power-on starts the start-up delay
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.mode <= MD_STARTUP;
            st_reg.wdt_prescale <= RST_WDT_PRESCALE;
            st_reg.clock_mode <= RST_CLOCK_MODE;
            st_reg.wake_mask <= RST_WAKE_MASK;
            st_reg.rst_pin_sync <= 2'h3;
            st_reg.ctrl.full_reset <= 1'b1;
            st_reg.ctrl.osc_32k_en <= 1'b1;
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign avs_readdata_o = st_reg.rdata;
    assign avs_waitrequest_o = !st_reg.resp_valid;
    assign ctrl_o = st_reg.ctrl;

    // Halt entry sets power-down and clears timeout
    halt_flags_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && awake && halt_exec_i && !pin_reset && !wdt_timeout_i
        && st_reg.clock_mode[7:5] == 3'b000 |=> halted && st_reg.pwr_down
        && !st_reg.wdt_timeout && st_reg.ctrl.osc_32k_en)
        else $error("halt did not enter sleep with flags");

    // Idle stops both oscillators
    idle_osc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_reg.mode == MD_IDLE |-> !st_reg.ctrl.osc_32k_en && !st_reg.ctrl.osc_fast_en)
        else $error("oscillator running in idle");

    // Halted modes stop the core clock
    halt_stop_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        halted |-> !st_reg.ctrl.core_run)
        else $error("core running while halted");

    // Start-up lasts exactly 1024 cycles
    sequence startup_enter_s;
        clk_en_i && !pin_reset && st_reg.mode == MD_STARTUP && st_reg.startup_cnt == '0;
    endsequence
    startup_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_reg.mode == MD_STARTUP && st_reg.startup_cnt == 11'd1023 && clk_en_i
        && !pin_reset && !wdt_timeout_i |=> st_reg.mode == MD_GREEN)
        else $error("start-up did not end in green");

    // Normal only with freq-up settled
    normal_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(st_reg.mode == MD_NORMAL) |-> st_reg.settle_done
        && st_reg.clock_mode[BIT_FAST_SEL] && st_reg.ctrl.fast_clk_sel)
        else $error("normal entered without settle");

    // Pending interrupt at halt cannot wake
    pend_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        halted && |(irq_wake & ~st_reg.irq_armed) |-> 1'b0)
        else $error("pending interrupt armed");

    // Resume-at-interrupt pulse excludes resume-next and lands in Green
    resume_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_reg.ctrl.resume_irq |-> !st_reg.ctrl.resume_next && st_reg.mode == MD_GREEN)
        else $error("resume pulses conflict");

    // Pin reset in halt gives flags 0,1 and clears freq-up
    pin_halt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && halted && pin_reset |=> !st_reg.wdt_timeout && st_reg.pwr_down
        && st_reg.clock_mode[7:5] == 3'b000 && st_reg.ctrl.full_reset)
        else $error("pin reset in halt wrong");

    // Watchdog in halt is warm reset with both flags
    wdt_warm_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && halted && !pin_reset && wdt_timeout_i && wdt_live_halt
        |=> st_reg.ctrl.warm_reset && !st_reg.ctrl.full_reset
        && st_reg.wdt_timeout && st_reg.pwr_down)
        else $error("watchdog warm reset wrong");

    // Start-up counter advances from zero
    startup_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        startup_enter_s |=> st_reg.mode == MD_STARTUP
        && st_reg.startup_cnt == 11'd1)
        else $error("start-up counter stuck");

    // A halt that is taken in an awake mode
    sequence halt_taken_s;
        clk_en_i && awake && halt_exec_i && !st_reg.clock_mode[BIT_FAST_SEL]
        && !st_reg.clock_mode[BIT_FREQ_UP] && !pin_reset && !wdt_timeout_i;
    endsequence

    // Halt clears the watchdog
    halt_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        halt_taken_s |=> st_reg.ctrl.wdt_clear
        && halted && st_reg.pwr_down)
        else $error("halt did not clear watchdog");

    // Halt with freq-up set is ignored
    halt_ignore_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && awake && halt_exec_i
        && st_reg.clock_mode[BIT_FREQ_UP] |=> !halted)
        else $error("halt taken with freq-up set");

    // Sleep keeps the slow oscillator only
    sleep_osc_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_reg.mode == MD_SLEEP |-> st_reg.ctrl.osc_32k_en
        && !st_reg.ctrl.osc_fast_en && !st_reg.ctrl.core_run)
        else $error("sleep oscillators wrong");

    // Masked port A change wakes into start-up
    port_wake_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && halted && |pa_wake && !pin_reset && !wdt_timeout_i
        |=> st_reg.mode == MD_STARTUP && st_reg.startup_cnt == '0)
        else $error("port A did not wake");

    // Slow-clock interrupts cannot leave Idle
    idle_dead_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        st_reg.mode == MD_IDLE && !(|(irq_flag_i & st_reg.irq_armed & ~IRQ_SLOW_SRC))
        && !(|pa_wake) && !pin_reset && !wdt_timeout_i
        |=> st_reg.mode == MD_IDLE)
        else $error("idle left on dead source");

    // Watchdog run follows its source in halt
    wdt_halt_run_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        halted |-> st_reg.ctrl.wdt_run == wdt_live_halt)
        else $error("watchdog run wrong in halt");

    // Port snapshot held while halted
    port_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        halted && $past(halted) |-> $stable(st_reg.pa_last))
        else $error("port state moved in halt");

    // Awake watchdog timeout is a full reset
    awake_wdt_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && awake && !pin_reset && wdt_timeout_i
        |=> st_reg.ctrl.full_reset && st_reg.wdt_timeout && st_reg.mode == MD_STARTUP
        && st_reg.wdt_prescale == RST_WDT_PRESCALE)
        else $error("awake watchdog reset wrong");

    // Warm reset keeps the prescale setting
    warm_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && halted && !pin_reset && wdt_timeout_i && wdt_live_halt
        && !avs_write_i |=> $stable(st_reg.wdt_prescale))
        else $error("warm reset changed prescale");

    // Awake pin reset leaves both flags
    pin_awake_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && awake && pin_reset && !halt_exec_i
        |=> st_reg.ctrl.full_reset && $stable(st_reg.pwr_down)
        && $stable(st_reg.wdt_timeout))
        else $error("awake pin reset flags wrong");

    // Pin reset clears fast select and osc stop
    reset_fast_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && pin_reset |=> !st_reg.clock_mode[BIT_FAST_SEL]
        && !st_reg.clock_mode[BIT_OSC_STOP])
        else $error("reset kept mode bits");

    // Non-interrupt wake resumes at next instruction
    resume_next_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && st_reg.mode == MD_STARTUP && st_reg.startup_cnt == 11'd1023
        && !pin_reset && !st_reg.wake_by_irq
        |=> st_reg.ctrl.resume_next && !st_reg.ctrl.resume_irq)
        else $error("resume next missing");

    // Bus answer one cycle after acceptance
    bus_answer_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clk_en_i && acc_hit |=> !avs_waitrequest_o)
        else $error("bus answer late");
endmodule // pmr_sequencer
`default_nettype wire

// *** include/pmr_pkg.sv ***
`default_nettype none
package pmr_pkg;
    // Register offsets; printed offsets are not all multiples of four, so byte address = 4*index
    localparam logic [7:0] IDX_WDT_PRESCALE = 8'h09;
    localparam logic [7:0] IDX_PROC_STATUS = 8'h0a;
    localparam logic [7:0] IDX_CLOCK_MODE = 8'h26;
    localparam logic [7:0] IDX_SEQ_STATUS = 8'h40;
    localparam logic [7:0] IDX_HALT_CMD = 8'h41;
    localparam logic [7:0] IDX_WAKE_MASK = 8'h42;
    localparam int ADDR_W = 10;
    // Field positions in the clock mode register
    localparam int BIT_FREQ_UP = 5;
    localparam int BIT_OSC_STOP = 6;
    localparam int BIT_FAST_SEL = 7;
    // Field positions in the processor status register
    localparam int BIT_PWR_DOWN = 4;
    localparam int BIT_WDT_TIMEOUT = 5;
    // Reset values
    localparam logic [7:0] RST_WDT_PRESCALE = 8'h07;
    localparam logic [7:0] RST_CLOCK_MODE = 8'h00;
    localparam logic [7:0] RST_WAKE_MASK = 8'hff;
    // Start-up delay in system clock periods
    localparam int STARTUP_CYCLES = 1024;
    localparam int STARTUP_W = 11;
    // Frequency-up settle time
    localparam int FREQ_SETTLE_MS = 20;
    localparam int CLK_HZ = 10000000;
    localparam longint FREQ_SETTLE_CYC_L = (longint'(FREQ_SETTLE_MS) * CLK_HZ + 999) / 1000;
    localparam int FREQ_SETTLE_CYCLES = int'(FREQ_SETTLE_CYC_L);
    // Watchdog clock sources
    localparam logic [1:0] WDT_SRC_INSTR = 2'h0;
    localparam logic [1:0] WDT_SRC_32K = 2'h1;
    localparam logic [1:0] WDT_SRC_RC = 2'h2;

    typedef enum logic [2:0] {MD_NORMAL, MD_GREEN, MD_SLEEP, MD_IDLE, MD_STARTUP} pmr_mode_e;

    // Core-facing control bundle
    typedef struct packed {
        logic core_run;
        logic fast_clk_sel;
        logic osc_32k_en;
        logic osc_fast_en;
        logic wdt_clear;
        logic wdt_run;
        logic warm_reset;
        logic full_reset;
        logic resume_irq;
        logic resume_next;
    } pmr_ctrl_s;

    // Whole state of the sequencer
    typedef struct packed {
        pmr_mode_e mode;
        logic [7:0] wdt_prescale;
        logic [7:0] clock_mode;
        logic pwr_down;
        logic wdt_timeout;
        logic [3:0] status_low;
        logic [7:0] wake_mask;
        logic [5:0] irq_armed;
        logic wake_by_irq;
        logic [STARTUP_W-1:0] startup_cnt;
        logic [24:0] settle_cnt;
        logic settle_done;
        logic [1:0] rst_pin_sync;
        logic [7:0] pa_sync0;
        logic [7:0] pa_sync1;
        logic [7:0] pa_last;
        logic resp_valid;
        logic [31:0] rdata;
        pmr_ctrl_s ctrl;
    } pmr_state_s;
endpackage
`default_nettype wire

// *** tb/tb_power_mode_reset_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_power_mode_reset_sequencer import pmr_pkg::*;;
    logic clk_sys_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic ext_reset_n_i, halt_exec_i, wdt_timeout_i, stack_full_i, clk_en_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [3:0] avs_byteenable_i;
    logic [7:0] port_a_i, rd;
    logic [5:0] irq_flag_i, irq_enable_i;
    pmr_ctrl_s ctrl_o, seen;
    int error_cnt, tests_run, n;

    pmr_sequencer #(.SETTLE_CYCLES(4)) pmr_sequencer_inst (.clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ext_reset_n_i(ext_reset_n_i),
        .port_a_i(port_a_i), .halt_exec_i(halt_exec_i), .wdt_timeout_i(wdt_timeout_i),
        .irq_flag_i(irq_flag_i), .irq_enable_i(irq_enable_i), .stack_full_i(stack_full_i),
        .ctrl_o(ctrl_o));

    // Clock at 10 MHz
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // Sticky capture of one-cycle control pulses
    always @(posedge clk_sys_i) seen <= seen | ctrl_o;

    task automatic tally_and_finish();
        $display("Counts: tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon access, held until waitrequest is seen low at a falling edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        @(posedge clk_sys_i);
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_writedata_i <= {24'h0, wd};
        k = 0;
        do begin
            @(negedge clk_sys_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            tally_and_finish();
        end
        rd = avs_readdata_o[7:0];
        @(posedge clk_sys_i);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] mask, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd & mask, exp);
    endtask

    // Poll sequencer mode until it matches
    task automatic wait_mode(input pmr_mode_e m);
        int k;
        k = 0;
        do begin
            bus(1'b0, IDX_SEQ_STATUS, 8'h00);
            k++;
        end while (rd[2:0] !== m && k < 1500);
        chk({5'h0, rd[2:0]}, {5'h0, m});
        if (k >= 1500) tally_and_finish();
    endtask

    // Cycles from now until a resume pulse
    task automatic count_resume();
        n = 0;
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (!(seen.resume_next || seen.resume_irq) && n < 1300);
        if (n >= 1300) begin
            error_cnt++;
            tally_and_finish();
        end
    endtask

    task automatic pulse(input int which);
        @(posedge clk_sys_i);
        if (which == 0) halt_exec_i <= 1'b1; else wdt_timeout_i <= 1'b1;
        @(posedge clk_sys_i);
        halt_exec_i <= 1'b0;
        wdt_timeout_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic pin_reset();
        @(posedge clk_sys_i);
        ext_reset_n_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        ext_reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask

    task automatic t_reset_values();
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_STARTUP});
        rchk(IDX_WDT_PRESCALE, 8'hff, RST_WDT_PRESCALE);
        rchk(IDX_CLOCK_MODE, 8'he0, RST_CLOCK_MODE);
        rchk(IDX_PROC_STATUS, 8'h30, 8'h00);
        rchk(IDX_WAKE_MASK, 8'hff, RST_WAKE_MASK);
        rchk(IDX_HALT_CMD, 8'hff, 8'h00);
        bus(1'b1, 8'h50, 8'h5a);
        rchk(8'h50, 8'hff, 8'h00);
        wait_mode(MD_GREEN);
        $display("test reset_values done");
    endtask

    task automatic t_sleep_port_a();
        bus(1'b1, IDX_WAKE_MASK, 8'h01);
        bus(1'b1, IDX_CLOCK_MODE, 8'h00);
        irq_flag_i <= 6'h04;
        clk_en_i <= 1'b0;
        pulse(0);
        clk_en_i <= 1'b1;
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_GREEN});
        seen = '0;
        pulse(0);
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_SLEEP});
        chk({5'h0, ctrl_o.core_run, ctrl_o.osc_32k_en, ctrl_o.osc_fast_en}, 8'h02);
        chk({7'h0, seen.wdt_clear}, 8'h01);
        rchk(IDX_PROC_STATUS, 8'h30, 8'h10);
        port_a_i <= 8'h02;
        repeat (40) @(posedge clk_sys_i);
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_SLEEP});
        port_a_i <= 8'h03;
        count_resume();
        chk({7'h0, (n >= 1024 && n <= 1040)}, 8'h01);
        chk({6'h0, seen.resume_next, seen.resume_irq}, 8'h02);
        wait_mode(MD_GREEN);
        irq_flag_i <= 6'h00;
        $display("test sleep_port_a done");
    endtask

    task automatic t_idle_irq();
        bus(1'b1, IDX_CLOCK_MODE, 8'h40);
        pulse(0);
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_IDLE});
        chk({6'h0, ctrl_o.osc_32k_en, ctrl_o.osc_fast_en}, 8'h00);
        irq_flag_i <= 6'h02;
        repeat (40) @(posedge clk_sys_i);
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_IDLE});
        seen = '0;
        irq_flag_i <= 6'h03;
        count_resume();
        chk({6'h0, seen.resume_next, seen.resume_irq}, 8'h01);
        wait_mode(MD_GREEN);
        rchk(IDX_SEQ_STATUS, 8'h08, 8'h08);
        irq_flag_i <= 6'h00;
        bus(1'b1, IDX_CLOCK_MODE, 8'h00);
        pulse(0);
        stack_full_i <= 1'b1;
        seen = '0;
        irq_flag_i <= 6'h01;
        count_resume();
        chk({6'h0, seen.resume_next, seen.resume_irq}, 8'h02);
        wait_mode(MD_GREEN);
        irq_flag_i <= 6'h00;
        stack_full_i <= 1'b0;
        $display("test idle_irq done");
    endtask

    task automatic t_normal_wdt();
        bus(1'b1, IDX_WDT_PRESCALE, 8'h3c);
        bus(1'b1, IDX_CLOCK_MODE, 8'h20);
        pulse(0);
        rchk(IDX_SEQ_STATUS, 8'h07, {5'h0, MD_GREEN});
        repeat (10) @(posedge clk_sys_i);
        bus(1'b1, IDX_CLOCK_MODE, 8'ha0);
        wait_mode(MD_NORMAL);
        chk({6'h0, ctrl_o.fast_clk_sel, ctrl_o.osc_fast_en}, 8'h03);
        seen = '0;
        pulse(1);
        chk({7'h0, seen.full_reset}, 8'h01);
        wait_mode(MD_GREEN);
        rchk(IDX_CLOCK_MODE, 8'he0, 8'h20);
        rchk(IDX_WDT_PRESCALE, 8'hff, RST_WDT_PRESCALE);
        rchk(IDX_PROC_STATUS, 8'h30, 8'h30);
        $display("test normal_wdt done");
    endtask

    task automatic t_pin_and_warm();
        pin_reset();
        wait_mode(MD_GREEN);
        rchk(IDX_PROC_STATUS, 8'h30, 8'h30);
        rchk(IDX_CLOCK_MODE, 8'he0, 8'h20);
        bus(1'b1, IDX_CLOCK_MODE, 8'h40);
        pulse(0);
        pin_reset();
        wait_mode(MD_GREEN);
        rchk(IDX_PROC_STATUS, 8'h30, 8'h10);
        rchk(IDX_CLOCK_MODE, 8'he0, 8'h00);
        bus(1'b1, IDX_WDT_PRESCALE, 8'h3c);
        pulse(0);
        seen = '0;
        pulse(1);
        chk({6'h0, seen.warm_reset, seen.full_reset}, 8'h02);
        wait_mode(MD_GREEN);
        rchk(IDX_PROC_STATUS, 8'h30, 8'h30);
        rchk(IDX_WDT_PRESCALE, 8'hff, 8'h3c);
        $display("test pin_and_warm done");
    endtask

    initial begin
        rst_n_i = 1'b0;
        clk_en_i = 1'b1;
        ext_reset_n_i = 1'b1;
        avs_address_i = '0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = '0;
        avs_byteenable_i = 4'h1;
        port_a_i = 8'h00;
        halt_exec_i = 1'b0;
        wdt_timeout_i = 1'b0;
        irq_flag_i = 6'h00;
        irq_enable_i = 6'h3f;
        stack_full_i = 1'b0;
        seen = '0;
        error_cnt = 0;
        tests_run = 0;
        repeat (3) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_sleep_port_a();
        t_idle_irq();
        t_normal_wdt();
        t_pin_and_warm();
        tally_and_finish();
    end
endmodule // tb_power_mode_reset_sequencer
`default_nettype wire
